// *** hdl/cal_ctrl.sv ***
// Calibration control register bank with output pin steering and correction.
`timescale 1ns/10ps
module cal_ctrl
	import cal_ctrl_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	input  wire logic              sync_pin,
	output logic      [1:0]        gpo_out,
	output logic      [1:0]        gpio_out,
	output logic      [1:0]        gpio_oe,
	output logic                   sync_armed,
	output logic                   sync_event,
	output logic      [7:0]        amp_gain
);
	typedef struct packed {
		ctrl_type          ctrl;
		logic [2:0]        amp_gain_code;
		logic [DATA_W-1:0] sys_ofs_if;
		logic [DATA_W-1:0] sys_gain_if;
		logic [DATA_W-1:0] self_ofs_if;
		logic [DATA_W-1:0] self_gain_if;
		logic [DATA_W-1:0] sys_ofs_int;
		logic [DATA_W-1:0] sys_gain_int;
		logic [DATA_W-1:0] self_ofs_int;
		logic [DATA_W-1:0] self_gain_int;
		logic [CH_N*CH_FLD-1:0] channel_map;
		logic [1:0]        output_pin_direction_reg;
		logic [3:0]        gpio_ctrl;
		logic [1:0]        seq_mode;
		logic [2:0]        seq_channel;
		logic [DATA_W-1:0] sample;
		logic [DATA_W-1:0] result;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        gpo_out;
		logic [1:0]        gpio_out;
		logic [1:0]        gpio_oe;
		logic              sync_armed;
		logic              sync_event;
		logic              sync_last;
		logic [7:0]        amp_gain;
	} state_type;

	state_type         state_reg;
	state_type         state_next;
	logic              sync_s;
	logic [DATA_W-1:0] mid;
	logic [DATA_W-1:0] corrected;
	logic [CH_FLD-1:0] ch_fld;

	pin_sync u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  (sync_pin),
		.pin_out (sync_s)
	);

	// Self calibration stage first, system calibration second.
	cal_correct u_self (
		.din           (state_reg.sample),
		.offset        (state_reg.self_ofs_int),
		.gain          (state_reg.self_gain_int),
		.offset_bypass (state_reg.ctrl.self_offset_bypass),
		.gain_bypass   (state_reg.ctrl.self_gain_bypass),
		.dout          (mid)
	);
	cal_correct u_sys (
		.din           (mid),
		.offset        (state_reg.sys_ofs_int),
		.gain          (state_reg.sys_gain_int),
		.offset_bypass (state_reg.ctrl.system_offset_bypass),
		.gain_bypass   (state_reg.ctrl.system_gain_bypass),
		.dout          (corrected)
	);

	assign ch_fld = state_reg.channel_map[state_reg.seq_channel*CH_FLD +: CH_FLD];

	// Next state: register writes, readback, pin steering and sync.
	always_comb begin
		state_next = state_reg;
		state_next.sync_event = 1'b0;
		state_next.rdata = '0;
		if (wr) begin
			case (addr)
				ADDR_CTRL: state_next.ctrl = ctrl_type'(wdata[7:0]);
				ADDR_GAIN: state_next.amp_gain_code = wdata[2:0];
				ADDR_SOC: begin
					state_next.sys_ofs_if  = wdata;
					state_next.sys_ofs_int = wdata;
				end
				ADDR_SGC: begin
					state_next.sys_gain_if  = wdata;
					state_next.sys_gain_int = wdata;
				end
				ADDR_SCOC: begin
					state_next.self_ofs_if  = wdata;
					state_next.self_ofs_int = wdata;
				end
				ADDR_SCGC: begin
					state_next.self_gain_if  = wdata;
					state_next.self_gain_int = wdata;
				end
				ADDR_MAPLO: state_next.channel_map[0 +: 3*CH_FLD] =
					wdata[3*CH_FLD-1:0];
				ADDR_MAPHI: state_next.channel_map[3*CH_FLD +: 3*CH_FLD] =
					wdata[3*CH_FLD-1:0];
				ADDR_ODIR: state_next.output_pin_direction_reg = wdata[1:0];
				ADDR_GPIO: state_next.gpio_ctrl = wdata[3:0];
				ADDR_SEQ: state_next.seq_mode = wdata[1:0];
				ADDR_STEP: begin
					if (wdata[2:0] < 3'(CH_N))
						state_next.seq_channel = wdata[2:0];
				end
				ADDR_SAMPLE: state_next.sample = wdata;
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				ADDR_CTRL: state_next.rdata = {16'h0000, state_reg.ctrl};
				ADDR_GAIN: state_next.rdata = {21'h000000,
					state_reg.amp_gain_code};
				// Interface copy or internal copy per readback select.
				ADDR_SOC: state_next.rdata = state_reg.ctrl.cal_readback_select ?
					state_reg.sys_ofs_if : state_reg.sys_ofs_int;
				ADDR_SGC: state_next.rdata = state_reg.ctrl.cal_readback_select ?
					state_reg.sys_gain_if : state_reg.sys_gain_int;
				ADDR_SCOC: state_next.rdata = state_reg.ctrl.cal_readback_select ?
					state_reg.self_ofs_if : state_reg.self_ofs_int;
				ADDR_SCGC: state_next.rdata = state_reg.ctrl.cal_readback_select ?
					state_reg.self_gain_if : state_reg.self_gain_int;
				ADDR_MAPLO: state_next.rdata = DATA_W'(
					state_reg.channel_map[0 +: 3*CH_FLD]);
				ADDR_MAPHI: state_next.rdata = DATA_W'(
					state_reg.channel_map[3*CH_FLD +: 3*CH_FLD]);
				ADDR_ODIR: state_next.rdata = DATA_W'(
					state_reg.output_pin_direction_reg);
				ADDR_GPIO: state_next.rdata = DATA_W'(state_reg.gpio_ctrl);
				ADDR_SEQ: state_next.rdata = DATA_W'(state_reg.seq_mode);
				ADDR_STEP: state_next.rdata = DATA_W'(state_reg.seq_channel);
				ADDR_SAMPLE: state_next.rdata = state_reg.sample;
				ADDR_RESULT: state_next.rdata = state_reg.result;
				default: state_next.rdata = '0;
			endcase
		end
		state_next.result = corrected;
		// Gain is one shifted by the code.
		state_next.amp_gain = 8'h01 << state_reg.amp_gain_code;
		// Mode 3 with sequencing: pins follow the stepped channel pairing.
		if (state_reg.seq_mode == SEQ_M3 &&
			state_reg.ctrl.output_sequencing_select) begin
			state_next.gpo_out  = ch_fld[POS_GPOEN] ?
				ch_fld[POS_GPO +: 2] : 2'h0;
			state_next.gpio_out = ch_fld[POS_GPOEN] ?
				ch_fld[POS_GPO +: 2] : 2'h0;
			state_next.gpio_oe  = state_reg.gpio_ctrl[3:2];
		end else begin
			state_next.gpo_out  = state_reg.output_pin_direction_reg;
			state_next.gpio_out = state_reg.gpio_ctrl[1:0];
			state_next.gpio_oe  = state_reg.gpio_ctrl[3:2];
		end
		// Sync arms only with the enable bit; rising pin edge gives an event.
		state_next.sync_armed = state_reg.ctrl.sync_enable;
		state_next.sync_last  = sync_s;
		state_next.sync_event = state_reg.ctrl.sync_enable &&
			sync_s && !state_reg.sync_last;
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.ctrl <= ctrl_type'(CTRL_RESET);
			state_reg.sys_gain_if <= UNITY_GAIN;
			state_reg.sys_gain_int <= UNITY_GAIN;
			state_reg.self_gain_if <= UNITY_GAIN;
			state_reg.self_gain_int <= UNITY_GAIN;
			state_reg.amp_gain <= 8'h01;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata      = state_reg.rdata;
	assign gpo_out    = state_reg.gpo_out;
	assign gpio_out   = state_reg.gpio_out;
	assign gpio_oe    = state_reg.gpio_oe;
	assign sync_armed = state_reg.sync_armed;
	assign sync_event = state_reg.sync_event;
	assign amp_gain   = state_reg.amp_gain;

	// Checks.
	gain_power_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		wr && addr == ADDR_GAIN |=> ##1 amp_gain == (8'h01 << $past(wdata[2:0], 2)))
		else $error("amp gain wrong");
	seq_pins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.seq_mode == SEQ_M3 && state_reg.ctrl.output_sequencing_select
		&& ch_fld[POS_GPOEN] |=> gpo_out == $past(ch_fld[POS_GPO +: 2]))
		else $error("sequenced pins wrong");
	direct_pins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!state_reg.ctrl.output_sequencing_select |=>
		gpo_out == $past(state_reg.output_pin_direction_reg))
		else $error("direct pins wrong");
	mode_ignore_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.seq_mode != SEQ_M3 |=>
		gpio_out == $past(state_reg.gpio_ctrl[1:0]))
		else $error("select not ignored");
	sync_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!state_reg.ctrl.sync_enable |=> !sync_event && !sync_armed)
		else $error("sync while disabled");
	readback_sel_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		rd && addr == ADDR_SOC && state_reg.ctrl.cal_readback_select |=>
		rdata == $past(state_reg.sys_ofs_if))
		else $error("readback wrong");
	sys_bypass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.ctrl.system_gain_bypass && state_reg.ctrl.system_offset_bypass
		|=> state_reg.result == $past(mid))
		else $error("system bypass wrong");
	self_bypass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.ctrl.self_gain_bypass && state_reg.ctrl.self_offset_bypass
		|-> mid == state_reg.sample)
		else $error("self bypass wrong");
	seq_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn)
		state_reg.seq_mode == SEQ_M3 && state_reg.ctrl.output_sequencing_select);
	sync_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn)
		sync_event);
	rb_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn)
		rd && addr == ADDR_SCGC && !state_reg.ctrl.cal_readback_select);
endmodule

// *** hdl/cal_ctrl_pkg.sv ***
// Package with register map, field positions and shared types of the calibration control block.
// Summary of operation
// - The amplifier gain is two to the power of the 3-bit gain code, so code 0 gives 1 and code 7 gives 128.
// - In sequencer mode 3 with the output sequencing select at 1, output pins follow the per-channel pairing of the channel maps.
// - With the output sequencing select at 0, output pins follow the direction register and GPIO pins the GPIO control register.
// - The output sequencing select is ignored in sequencer modes 1 and 2.
// - Pin-based conversion synchronization is enabled only while the sync enable bit is 1.
// - A coefficient read returns the last interface-written value when readback select is 1, else the internal value.
// - The system gain coefficient is left out of the corrected result when its bypass bit is 1.
// - The system offset coefficient is left out of the corrected result when its bypass bit is 1.
// - The self-calibration gain coefficient is left out when its bypass bit is 1.
// - The self-calibration offset coefficient is left out when its bypass bit is 1.
package cal_ctrl_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 24;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_GAIN   = 4'h1;
	localparam logic [3:0] ADDR_SOC    = 4'h2;
	localparam logic [3:0] ADDR_SGC    = 4'h3;
	localparam logic [3:0] ADDR_SCOC   = 4'h4;
	localparam logic [3:0] ADDR_SCGC   = 4'h5;
	localparam logic [3:0] ADDR_MAPLO  = 4'h6;
	localparam logic [3:0] ADDR_MAPHI  = 4'h7;
	localparam logic [3:0] ADDR_ODIR   = 4'h8;
	localparam logic [3:0] ADDR_GPIO   = 4'h9;
	localparam logic [3:0] ADDR_SEQ    = 4'ha;
	localparam logic [3:0] ADDR_STEP   = 4'hb;
	localparam logic [3:0] ADDR_SAMPLE = 4'hc;
	localparam logic [3:0] ADDR_RESULT = 4'hd;
	localparam logic [7:0] CTRL_RESET  = 8'h1c;
	localparam logic [7:0] GAIN_RESET  = 8'h00;
	localparam logic [23:0] OFS_RESET  = 24'h000000;
	localparam logic [23:0] UNITY_GAIN = 24'h800000; // 1.0 in Q1.23.
	localparam int GAIN_FRAC = 23;
	localparam int CH_N = 6;
	localparam int CH_FLD = 7;  // Per-channel map field width.
	localparam int POS_GPOEN = 0;
	localparam int POS_GPO = 5;
	localparam int SEQ_MODE3 = 3;
	localparam logic [1:0] SEQ_M3 = 2'h3;
	// Bit 7 is unused; bits 6 to 0 give the 0x1c reset pattern.
	typedef struct packed {
		logic spare;
		logic output_sequencing_select;
		logic sync_enable;
		logic cal_readback_select;
		logic system_gain_bypass;
		logic system_offset_bypass;
		logic self_gain_bypass;
		logic self_offset_bypass;
	} ctrl_type;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_type;
endpackage

// *** hdl/pin_sync.sv ***
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/10ps
module pin_sync (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic pin_in,
	output logic      pin_out
);
	logic meta_reg;

	// First stage is read only by the second stage.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= 1'b0;
			pin_out  <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			pin_out  <= meta_reg;
		end
	end
endmodule

// *** hdl/cal_correct.sv ***
// One correction stage: offset subtract then gain multiply, each bypassable.
`timescale 1ns/10ps
module cal_correct
	import cal_ctrl_pkg::*;
(
	input  wire logic [DATA_W-1:0] din,
	input  wire logic [DATA_W-1:0] offset,
	input  wire logic [DATA_W-1:0] gain,
	input  wire logic              offset_bypass,
	input  wire logic              gain_bypass,
	output logic      [DATA_W-1:0] dout
);
	logic [DATA_W-1:0]   ofs_use;
	logic [DATA_W-1:0]   gain_use;
	logic [DATA_W-1:0]   diff;
	logic [2*DATA_W-1:0] prod;

	// Bypassed terms turn into identity values.
	always_comb begin
		ofs_use  = offset_bypass ? OFS_RESET : offset;
		gain_use = gain_bypass ? UNITY_GAIN : gain;
		diff     = din - ofs_use;
		prod     = $signed(diff) * $signed({1'b0, gain_use[DATA_W-1:1]});
		dout     = prod[GAIN_FRAC-1 +: DATA_W];
	end
endmodule

// *** verification/tb_cal_ctrl.sv ***
// Self-checking testbench for the calibration control register bank.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
	err_count++; $display("[ERR] %s expected %h seen %h", nm, exp, got); \
	end end
module tb_cal_ctrl
	import cal_ctrl_pkg::*;
;
	logic              clk_sys;
	logic              rstn;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              sync_pin;
	logic [1:0]        gpo_out;
	logic [1:0]        gpio_out;
	logic [1:0]        gpio_oe;
	logic              sync_armed;
	logic              sync_event;
	logic [7:0]        amp_gain;
	logic [DATA_W-1:0] d;
	logic [7:0]        ctl_tab [6];
	int                err_count;
	int                checks;
	int                hits;

	cal_ctrl uut (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.addr       (addr),
		.wdata      (wdata),
		.wr         (wr),
		.rd         (rd),
		.rdata      (rdata),
		.sync_pin   (sync_pin),
		.gpo_out    (gpo_out),
		.gpio_out   (gpio_out),
		.gpio_oe    (gpio_oe),
		.sync_armed (sync_armed),
		.sync_event (sync_event),
		.amp_gain   (amp_gain)
	);

	// The 200 MHz system clock.
	always #2.5 clk_sys = ~clk_sys;

	// One write cycle, then two edges so derived outputs have settled.
	task automatic wr_reg(input logic [3:0] a, input logic [23:0] v);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// One read cycle; the data are taken in the single cycle they stand.
	task automatic rd_reg(input logic [3:0] a, output logic [23:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	// Pulses the sync pin and counts event pulses over a bounded window.
	task automatic sync_pulse(output int n);
		n = 0;
		@(posedge clk_sys);
		sync_pin <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			#1;
			if (sync_event === 1'b1) n++;
		end
		@(posedge clk_sys);
		sync_pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Expected corrected result for sample 0x100 and the coefficients below.
	function automatic logic [23:0] calc(input logic [7:0] c);
		logic [47:0] v;
		v = 48'h100;
		if (!c[0]) v = v - 48'h10;
		if (!c[1]) v = (v * 48'h400000) >> 23;
		if (!c[2]) v = v - 48'h8;
		if (!c[3]) v = (v * 48'h400000) >> 23;
		return v[23:0];
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence of register accesses and pin observations.
	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		addr = 4'h0;
		wdata = 24'h000000;
		wr = 1'b0;
		rd = 1'b0;
		sync_pin = 1'b0;
		err_count = 0;
		checks = 0;
		ctl_tab = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0f};
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_reg(ADDR_CTRL, d);
		`CHK("ctrl reset", 24'h00001c, d)
		rd_reg(4'he, d);
		`CHK("unmapped read", 24'h000000, d)
		wr_reg(4'hf, 24'hffffff);
		rd_reg(ADDR_CTRL, d);
		`CHK("ctrl after unmapped write", 24'h00001c, d)
		for (int c = 0; c < 8; c++) begin
			wr_reg(ADDR_GAIN, 24'(c));
			`CHK("amp_gain", 8'(1 << c), amp_gain)
		end
		wr_reg(ADDR_CTRL, 24'h000020);
		`CHK("sync_armed on", 1'b1, sync_armed)
		sync_pulse(hits);
		`CHK("sync events enabled", 1, hits)
		wr_reg(ADDR_CTRL, 24'h000000);
		`CHK("sync_armed off", 1'b0, sync_armed)
		sync_pulse(hits);
		`CHK("sync events disabled", 0, hits)
		wr_reg(ADDR_SEQ, 24'h000003);
		wr_reg(ADDR_ODIR, 24'h000001);
		wr_reg(ADDR_GPIO, 24'h00000d);
		`CHK("gpo direct", 2'h1, gpo_out)
		`CHK("gpio direct", 2'h1, gpio_out)
		`CHK("gpio enables", 2'h3, gpio_oe)
		wr_reg(ADDR_MAPLO, 24'h000041);
		wr_reg(ADDR_MAPHI, 24'h000061);
		wr_reg(ADDR_STEP, 24'h000000);
		wr_reg(ADDR_CTRL, 24'h000040);
		`CHK("gpo step ch0", 2'h2, gpo_out)
		`CHK("gpio step ch0", 2'h2, gpio_out)
		wr_reg(ADDR_STEP, 24'h000003);
		`CHK("gpo step ch3", 2'h3, gpo_out)
		wr_reg(ADDR_STEP, 24'h000006);
		`CHK("gpo bad step", 2'h3, gpo_out)
		wr_reg(ADDR_STEP, 24'h000001);
		`CHK("gpo step ch1", 2'h0, gpo_out)
		wr_reg(ADDR_SEQ, 24'h000001);
		`CHK("output_sequencing_select 1", 2'h1, gpo_out)
		wr_reg(ADDR_SEQ, 24'h000002);
		`CHK("gpio mode 2", 2'h1, gpio_out)
		wr_reg(ADDR_SCOC, 24'h000010);
		wr_reg(ADDR_SCGC, 24'h400000);
		wr_reg(ADDR_SOC, 24'h000008);
		wr_reg(ADDR_SGC, 24'h400000);
		wr_reg(ADDR_SAMPLE, 24'h000100);
		for (int i = 0; i < 6; i++) begin
			wr_reg(ADDR_CTRL, {16'h0000, ctl_tab[i]});
			rd_reg(ADDR_RESULT, d);
			`CHK("result", calc(ctl_tab[i]), d)
		end
		wr_reg(ADDR_CTRL, 24'h000010);
		rd_reg(ADDR_SCOC, d);
		`CHK("coef interface copy", 24'h000010, d)
		wr_reg(ADDR_CTRL, 24'h000000);
		rd_reg(ADDR_SCOC, d);
		`CHK("coef internal copy", 24'h000010, d)
		rd_reg(ADDR_SCGC, d);
		`CHK("gain coef internal copy", 24'h400000, d)
		complete_run();
	end
endmodule
